// ### common/gdcfg_pkg.sv
// gdcfg_pkg: offsets, field positions, reset values and timing constants
// of the gate driver configuration register bank.
// assumes a 32-bit AHB-Lite bus with byte addresses.
package gdcfg_pkg;
	// printed offsets are not all multiples of four: they are word indices
	localparam logic [7:0] GDCFG_IDX_ONE = 8'hac;
	localparam logic [7:0] GDCFG_IDX_TWO = 8'hae;
	localparam logic [9:0] GDCFG_ADDR_ONE = {GDCFG_IDX_ONE, 2'b00};
	localparam logic [9:0] GDCFG_ADDR_TWO = {GDCFG_IDX_TWO, 2'b00};
	localparam int GDCFG_ADDR_W = 10;

	localparam logic [31:0] GDCFG_RESET_ONE = 32'h00228000;
	localparam logic [31:0] GDCFG_RESET_TWO = 32'h01200000;

	// register one fields
	localparam int GDCFG_PARITY = 31;
	localparam int GDCFG_SLEW_HI = 27;
	localparam int GDCFG_SLEW_LO = 26;
	localparam int GDCFG_CLEAR = 23;
	localparam int GDCFG_OVERVOLTAGE_LEVEL_SELECT = 19;
	localparam int GDCFG_OVP_ON = 18;
	localparam int GDCFG_OVERTEMP_WARNING_REPORT = 16;
	localparam int GDCFG_DEG_HI = 13;
	localparam int GDCFG_DEG_LO = 12;
	localparam int GDCFG_RETRY = 11;
	localparam int GDCFG_OC_LVL = 10;
	localparam int GDCFG_MODE_HI = 9;
	localparam int GDCFG_MODE_LO = 8;
	localparam int GDCFG_BEMF = 7;
	localparam int GDCFG_DEMAG_LS = 5;
	localparam int GDCFG_DEMAG_HS = 4;
	localparam int GDCFG_SYNC_REC = 3;
	localparam int GDCFG_ASYNC_REC = 2;
	localparam int GDCFG_GAIN_HI = 1;
	localparam int GDCFG_GAIN_LO = 0;
	// register two fields
	localparam int GDCFG_DCOMP_ON = 30;
	localparam int GDCFG_TDLY_HI = 29;
	localparam int GDCFG_TDLY_LO = 26;
	localparam int GDCFG_BUCK_SEQ_OFF = 24;
	localparam int GDCFG_BUCK_CURRENT_LIMIT = 23;

	typedef enum logic [1:0] {
		GDCFG_OC_LATCH = 2'h0,
		GDCFG_OC_RETRY = 2'h1,
		GDCFG_OC_REPORT = 2'h2,
		GDCFG_OC_IGNORE = 2'h3
	} gdcfg_ocmode_e;

	// timing at 250 MHz
	localparam int GDCFG_CLK_MHZ = 250;
	localparam int GDCFG_NS_PER_US = 1000;
	localparam int GDCFG_DEG_NS [4] = '{200, 600, 1200, 1600};
	localparam int GDCFG_RETRY_SHORT_MS = 5;
	localparam int GDCFG_RETRY_LONG_MS = 500;
	localparam int GDCFG_RETRY_SHORT_CYC = GDCFG_RETRY_SHORT_MS * GDCFG_CLK_MHZ * 1000;
	localparam int GDCFG_RETRY_LONG_CYC = GDCFG_RETRY_LONG_MS * GDCFG_CLK_MHZ * 1000;
	localparam int GDCFG_CNT_W = 27;
endpackage

// ### rtl/gdcfg_regs.sv
// gdcfg_regs: two gate driver configuration registers on AHB-Lite, plus
// the overcurrent filter, fault mode, retry timer and fault latch they steer.
// assumes the comparator and warning inputs arrive asynchronously from pins.
// assumes one 250 MHz clock; every timing count is in its cycles.
// assumes a zero-wait slave is acceptable: hreadyout is tied high.
// assumes word transfers only; hsize is not decoded.
// limitation: a read in a write's data phase returns the old value.
// bus timing
// address phase taken when hsel, hready and htrans[1] meet at an edge
// no wait states; hreadyout stays high and hresp stays okay
// write data lands at the edge that ends its data phase
// read data is captured at the address edge and stands till the next read
// unmapped reads return zero, unmapped writes are dropped
// only the low address bits are decoded, so the bank repeats upward
//
// register one
// clear bit is a command, never stored, always reads zero
// a one-cycle clear pulse rises at the same edge that stores the write
// parity and reserved bits are stored exactly as written
// none of them reaches any output; parity is never checked
//
// register two
// plain storage; buck sequencing comes out of reset disabled
// the target delay code goes out as-is, its time scale is downstream
//
// overcurrent path
// pin, two synchroniser stages, deglitch counter, then an event
// filter times come out as whole cycles at this clock
// any low sample restarts the filter count
// event sets the fault latch next edge, unless the mode ignores it
// latch reaches drive off and the fault pin one edge later
//
// fault modes
// latched: held until a clear command, drive off
// retrying: held until the retry wait runs out, drive off
// reporting: held until a clear, pin shows it, drive stays on
// ignored: latch forced low, nothing shown, nothing acted on
// a new event beats a clear landing in the same cycle
//
// retry wait
// counts only once the overcurrent has gone
// 5 ms or 500 ms by default, both overridable for short runs
// a persisting overcurrent keeps a retrying fault held
//
// fault pin
// active low, registered, so it never glitches
// shows any held fault except in the ignored mode
// warning level passes straight through while reporting is on
// the warning is not latched; it follows the synchronised pin
//
// limitations
// the deglitch counter shares its width with the retry counter,
// trading a few idle flops for one counter width
// a mode change takes effect on the next edge, mid-fault too
// a read in a write's data phase sees the old value
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/10ps
module gdcfg_regs
	import gdcfg_pkg::*;
#(
	parameter int retry_short_cyc = GDCFG_RETRY_SHORT_CYC,
	parameter int retry_long_cyc = GDCFG_RETRY_LONG_CYC
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic overcurrent_raw,
	input wire logic overtemp_warning_raw,
	output logic [1:0] slew_rate_code,
	output logic overvoltage_level_select,
	output logic overvoltage_protect_on,
	output logic overcurrent_trip_level,
	output logic back_emf_comparator_level,
	output logic demag_low_side_threshold,
	output logic demag_high_side_threshold,
	output logic sync_rectify_on,
	output logic async_rectify_on,
	output logic [1:0] current_sense_gain,
	output logic delay_comp_on,
	output logic [3:0] target_delay_code,
	output logic buck_sequencing_off,
	output logic buck_current_limit,
	output logic fault_clear_pulse,
	output logic overcurrent_fault,
	output logic drive_disable,
	output logic fault_indication_out_n
);
	// register storage and bus state
	logic [31:0] cfg_one_reg;
	logic [31:0] cfg_two_reg;
	logic wr_pend_reg;
	logic [GDCFG_ADDR_W-1:0] wr_addr_reg;
	logic [31:0] rd_data_reg;
	logic clear_reg;
	// pin synchronisers and overcurrent path state
	logic [1:0] oc_sync_reg;
	logic [1:0] otw_sync_reg;
	logic [GDCFG_CNT_W-1:0] deg_cnt_reg;
	logic oc_seen_reg;
	logic [GDCFG_CNT_W-1:0] retry_cnt_reg;
	logic oc_latch_reg;
	logic drive_off_reg;
	logic fault_n_reg;
	// bus decode
	logic addr_phase;
	logic [GDCFG_ADDR_W-1:0] a_addr;
	logic [GDCFG_CNT_W-1:0] deg_limit;
	logic [GDCFG_CNT_W-1:0] retry_limit;
	gdcfg_ocmode_e oc_mode;
	// decoded strobes and mode flags
	logic wr_one_hit;
	logic wr_two_hit;
	logic rd_req;
	logic [1:0] deg_code;
	logic mode_latching;
	logic mode_retrying;
	logic mode_reporting;
	logic mode_silent;
	logic fault_event;
	logic retry_done;
	logic otw_shown;
	logic fault_shown;

	// single-cycle slave, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rd_data_reg;
	assign addr_phase = hsel && hready && htrans[1];
	assign a_addr = haddr[GDCFG_ADDR_W-1:0];
	assign rd_req = addr_phase && !hwrite;

	// data-phase write strobes, one per register
	// upper address bits are not decoded, so the bank aliases
	assign wr_one_hit = wr_pend_reg && wr_addr_reg == GDCFG_ADDR_ONE;
	assign wr_two_hit = wr_pend_reg && wr_addr_reg == GDCFG_ADDR_TWO;

	// capture write address phase
	// hwdata only arrives one cycle later, so the
	// address is held here until the data phase edge
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= '0;
		end
		else
		begin
			wr_pend_reg <= addr_phase && hwrite;
			wr_addr_reg <= a_addr;
		end

	// register one; the clear bit never stores, so it reads back zero
	// parity and reserved bits are kept as written but drive nothing
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			cfg_one_reg <= GDCFG_RESET_ONE;
		else if (wr_one_hit)
		begin
			cfg_one_reg <= hwdata;
			cfg_one_reg[GDCFG_CLEAR] <= 1'b0;
		end

	// register two, plain storage
	// reserved and parity bits stored only, buck bit out of reset high
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			cfg_two_reg <= GDCFG_RESET_TWO;
		else if (wr_two_hit)
			cfg_two_reg <= hwdata;

	// clear command pulse from a write of one
	// one cycle wide, so a held bit cannot keep clearing;
	// writing zero to the bit issues no command
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			clear_reg <= 1'b0;
		else
			clear_reg <= wr_one_hit && hwdata[GDCFG_CLEAR];
	assign fault_clear_pulse = clear_reg;

	// read data registered in the data phase; unmapped reads zero
	// captured at the address edge, so hrdata stands through the
	// whole data phase and until the next read is taken
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			rd_data_reg <= '0;
		else if (rd_req)
		begin
			case (a_addr)
				GDCFG_ADDR_ONE:
					rd_data_reg <= cfg_one_reg;
				GDCFG_ADDR_TWO:
					rd_data_reg <= cfg_two_reg;
				default:
					rd_data_reg <= '0;
			endcase
		end

	// configuration outputs straight from the registers
	// no extra stage: the fields are flops already
	// register one, driver shaping and supply protection
	assign slew_rate_code = cfg_one_reg[GDCFG_SLEW_HI:GDCFG_SLEW_LO];
	assign overvoltage_level_select = cfg_one_reg[GDCFG_OVERVOLTAGE_LEVEL_SELECT];
	assign overvoltage_protect_on = cfg_one_reg[GDCFG_OVP_ON];

	// register one, overcurrent level and comparators
	assign overcurrent_trip_level = cfg_one_reg[GDCFG_OC_LVL];
	assign back_emf_comparator_level = cfg_one_reg[GDCFG_BEMF];
	assign demag_low_side_threshold = cfg_one_reg[GDCFG_DEMAG_LS];
	assign demag_high_side_threshold = cfg_one_reg[GDCFG_DEMAG_HS];

	// register one, rectification and sensing
	assign sync_rectify_on = cfg_one_reg[GDCFG_SYNC_REC];
	assign async_rectify_on = cfg_one_reg[GDCFG_ASYNC_REC];
	assign current_sense_gain = cfg_one_reg[GDCFG_GAIN_HI:GDCFG_GAIN_LO];

	// register two, delay compensation and buck
	assign delay_comp_on = cfg_two_reg[GDCFG_DCOMP_ON];
	assign target_delay_code = cfg_two_reg[GDCFG_TDLY_HI:GDCFG_TDLY_LO];
	assign buck_sequencing_off = cfg_two_reg[GDCFG_BUCK_SEQ_OFF];
	assign buck_current_limit = cfg_two_reg[GDCFG_BUCK_CURRENT_LIMIT];
	// fault mode field
	assign oc_mode = gdcfg_ocmode_e'(cfg_one_reg[GDCFG_MODE_HI:GDCFG_MODE_LO]);

	// fault mode decode; all four codes are legal, so no default
	always_comb
	begin
		mode_latching = 1'b0;
		mode_retrying = 1'b0;
		mode_reporting = 1'b0;
		mode_silent = 1'b0;
		unique case (oc_mode)
			GDCFG_OC_LATCH:
				mode_latching = 1'b1;
			GDCFG_OC_RETRY:
				mode_retrying = 1'b1;
			GDCFG_OC_REPORT:
				mode_reporting = 1'b1;
			GDCFG_OC_IGNORE:
				mode_silent = 1'b1;
		endcase
	end

	// pin synchronisers; first stage read only by the second
	// the pins change at any time; the two stages bound
	// metastability before the filter sees a level
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			oc_sync_reg <= '0;
			otw_sync_reg <= '0;
		end
		else
		begin
			oc_sync_reg <= {oc_sync_reg[0], overcurrent_raw};
			otw_sync_reg <= {otw_sync_reg[0], overtemp_warning_raw};
		end

	// filter length; least time so round up
	// this clock gives whole cycles, rounding only guards other clocks
	assign deg_code = cfg_one_reg[GDCFG_DEG_HI:GDCFG_DEG_LO];
	always_comb
	begin
		deg_limit = GDCFG_CNT_W'((GDCFG_DEG_NS[deg_code] * GDCFG_CLK_MHZ
			+ GDCFG_NS_PER_US - 1) / GDCFG_NS_PER_US);
		retry_limit = cfg_one_reg[GDCFG_RETRY] ? GDCFG_CNT_W'(retry_long_cyc)
			: GDCFG_CNT_W'(retry_short_cyc);
	end

	// deglitch: overcurrent must hold for the whole filter time
	// any low sample restarts the count, so a chain of short
	// spikes never adds up to a trip
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			deg_cnt_reg <= '0;
			oc_seen_reg <= 1'b0;
		end
		else if (!oc_sync_reg[1])
		begin
			deg_cnt_reg <= '0;
			oc_seen_reg <= 1'b0;
		end
		else if (deg_cnt_reg + 1'b1 >= deg_limit)
			oc_seen_reg <= 1'b1;
		else
			deg_cnt_reg <= deg_cnt_reg + 1'b1;

	// overcurrent event as the chosen mode sees it
	assign fault_event = oc_seen_reg && !mode_silent;
	// retry wait is over once the counter reaches the limit
	assign retry_done = mode_retrying && retry_cnt_reg >= retry_limit;

	// fault latch; a new event beats a same-cycle clear
	// otherwise a clear landing with a fresh trip would lose it
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			oc_latch_reg <= 1'b0;
		else if (fault_event)
			oc_latch_reg <= 1'b1;
		else if (clear_reg)
			oc_latch_reg <= 1'b0;
		else if (retry_done)
			oc_latch_reg <= 1'b0;
		else if (mode_silent)
			oc_latch_reg <= 1'b0;

	// retry wait counts only while a retrying fault is held
	// it starts only once the overcurrent has gone, so a
	// persisting fault keeps the outputs off indefinitely
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			retry_cnt_reg <= '0;
		else if (oc_latch_reg && mode_retrying && !oc_seen_reg)
			retry_cnt_reg <= retry_cnt_reg + 1'b1;
		else
			retry_cnt_reg <= '0;
	assign overcurrent_fault = oc_latch_reg;

	// drive off only in latched and retry modes
	// report mode keeps the bridge running by design
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			drive_off_reg <= 1'b0;
		else
			drive_off_reg <= oc_latch_reg && (mode_latching || mode_retrying);
	assign drive_disable = drive_off_reg;

	// what the fault pin shows: a held fault in any reporting mode,
	// and the warning level only while its report bit is set
	assign fault_shown = oc_latch_reg && (mode_latching || mode_retrying || mode_reporting);
	assign otw_shown = otw_sync_reg[1] && cfg_one_reg[GDCFG_OVERTEMP_WARNING_REPORT];

	// active-low fault pin; warning is not latched, it follows the pin
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			fault_n_reg <= 1'b1;
		else
			fault_n_reg <= !(fault_shown || otw_shown);
	assign fault_indication_out_n = fault_n_reg;
endmodule

// ### testbench/gdcfg_regs_checker.sv
// gdcfg_regs_checker: port-level checks of the gate driver register bank.
// assumes a zero-wait AHB-Lite slave on hclk, async active-low hresetn.
`timescale 1ns/10ps
module gdcfg_regs_checker
	import gdcfg_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [1:0] slew_rate_code,
	input wire logic overvoltage_level_select,
	input wire logic overvoltage_protect_on,
	input wire logic overcurrent_trip_level,
	input wire logic back_emf_comparator_level,
	input wire logic demag_low_side_threshold,
	input wire logic demag_high_side_threshold,
	input wire logic sync_rectify_on,
	input wire logic async_rectify_on,
	input wire logic [1:0] current_sense_gain,
	input wire logic delay_comp_on,
	input wire logic [3:0] target_delay_code,
	input wire logic buck_sequencing_off,
	input wire logic buck_current_limit,
	input wire logic fault_clear_pulse,
	input wire logic overcurrent_fault,
	input wire logic drive_disable
);
	logic w1_reg;
	logic w2_reg;
	logic [1:0] mode_reg;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// write data phases, so fields can be tied to the hwdata that set them
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			w1_reg <= 1'b0;
			w2_reg <= 1'b0;
		end
		else
		begin
			w1_reg <= hsel && hready && htrans[1] && hwrite && haddr == 32'(GDCFG_ADDR_ONE);
			w2_reg <= hsel && hready && htrans[1] && hwrite && haddr == 32'(GDCFG_ADDR_TWO);
		end
	end
	// shadow of the fault mode field, updated on the same edge as the register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			mode_reg <= 2'h0;
		else if (w1_reg)
			mode_reg <= hwdata[9:8];
	end
	sequence s_clr;
		fault_clear_pulse ##1 !fault_clear_pulse;
	endsequence
	property p_bus; hreadyout && !hresp; endproperty
	a_bus: assert property (p_bus) else $error("bus not ready or not okay");
	property p_slew; w1_reg |=> slew_rate_code == $past(hwdata[27:26]); endproperty
	a_slew: assert property (p_slew) else $error("slew code not stored");
	property p_clr; w1_reg && hwdata[23] |=> s_clr; endproperty
	a_clr: assert property (p_clr) else $error("clear pulse wrong");
	property p_noclr; w1_reg && !hwdata[23] |=> !fault_clear_pulse; endproperty
	a_noclr: assert property (p_noclr) else $error("spurious clear pulse");
	property p_ovp;
		w1_reg |=> {overvoltage_level_select, overvoltage_protect_on} == $past(hwdata[19:18]);
	endproperty
	a_ovp: assert property (p_ovp) else $error("overvoltage bits wrong");
	property p_low;
		w1_reg |=> {overcurrent_trip_level, back_emf_comparator_level, demag_low_side_threshold,
			demag_high_side_threshold, sync_rectify_on, async_rectify_on, current_sense_gain}
			== $past({hwdata[10], hwdata[7], hwdata[5:0]});
	endproperty
	a_low: assert property (p_low) else $error("lower fields wrong");
	property p_two;
		w2_reg |=> {delay_comp_on, target_delay_code, buck_sequencing_off, buck_current_limit}
			== $past({hwdata[30:26], hwdata[24:23]});
	endproperty
	a_two: assert property (p_two) else $error("register two fields wrong");
	property p_ign; $past(mode_reg) == 2'h3 && mode_reg == 2'h3 |-> !overcurrent_fault; endproperty
	a_ign: assert property (p_ign) else $error("fault latched in ignore mode");
	property p_rep; $past(mode_reg) == 2'h2 && mode_reg == 2'h2 |-> !drive_disable; endproperty
	a_rep: assert property (p_rep) else $error("drive disabled in report mode");
endmodule
bind gdcfg_regs gdcfg_regs_checker u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hready, .hreadyout, .hresp, .slew_rate_code, .overvoltage_level_select,
	.overvoltage_protect_on, .overcurrent_trip_level, .back_emf_comparator_level,
	.demag_low_side_threshold, .demag_high_side_threshold, .sync_rectify_on,
	.async_rectify_on, .current_sense_gain, .delay_comp_on, .target_delay_code,
	.buck_sequencing_off, .buck_current_limit, .fault_clear_pulse, .overcurrent_fault,
	.drive_disable);

// ### testbench/tb_gate_driver_config_regs.sv
// tb_gate_driver_config_regs: register, fault mode and warning tests.
// assumes short retry counts so retry faults clear within a few cycles.
`timescale 1ns/10ps
module tb_gate_driver_config_regs
	import gdcfg_pkg::*;
;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
	logic [1:0] htrans = 2'h0;
	logic hreadyout, hresp, overcurrent_raw = 1'b0, overtemp_warning_raw = 1'b0;
	logic overcurrent_fault, drive_disable, fault_indication_out_n, rd_v = 1'b0, st_v = 1'b0;
	logic [31:0] q[$];
	int n_fail = 0, checks = 0;
	gdcfg_regs #(.retry_short_cyc(20), .retry_long_cyc(40)) uut (.hclk, .hresetn, .hsel,
		.haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp, .overcurrent_raw, .overtemp_warning_raw, .slew_rate_code(),
		.overvoltage_level_select(), .overvoltage_protect_on(), .overcurrent_trip_level(),
		.back_emf_comparator_level(), .demag_low_side_threshold(), .demag_high_side_threshold(),
		.sync_rectify_on(), .async_rectify_on(), .current_sense_gain(), .delay_comp_on(),
		.target_delay_code(), .buck_sequencing_off(), .buck_current_limit(),
		.fault_clear_pulse(), .overcurrent_fault, .drive_disable, .fault_indication_out_n);
	initial
	begin
		forever #2 hclk = ~hclk;
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one single transfer; a read notes its expected data for the monitor
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		{hsel, hwrite, haddr, htrans} <= {1'b1, w, a, 2'h2};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, w ? d : 32'h0};
		if (!w) q.push_back(d);
		rd_v <= !w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd_v <= 1'b0;
	endtask
	// note {fault_n, fault, drive_disable} expected at the next edge
	task st(input logic [2:0] e);
		@(posedge hclk);
		q.push_back({29'h0, e});
		st_v <= 1'b1;
		@(posedge hclk);
		st_v <= 1'b0;
	endtask
	// monitor: oldest note against whatever result shows at this edge
	always @(posedge hclk)
	begin
		if (rd_v) chk(hrdata, q.pop_front());
		if (st_v) chk({29'h0, fault_indication_out_n, overcurrent_fault, drive_disable},
			q.pop_front());
	end
	task finish_test;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge hclk);
		n_fail++;
		finish_test;
	end
	initial
	begin
		void'($urandom(37998));
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		bus(0, 32'(GDCFG_ADDR_ONE), GDCFG_RESET_ONE);
		bus(0, 32'(GDCFG_ADDR_TWO), GDCFG_RESET_TWO);
		bus(1, 32'h10, 32'hffffffff);
		bus(0, 32'h10, 32'h0);
		repeat (4)
		begin
			r = $urandom;
			bus(1, 32'(GDCFG_ADDR_ONE), r);
			bus(0, 32'(GDCFG_ADDR_ONE), r & ~32'h00800000);
			bus(1, 32'(GDCFG_ADDR_TWO), ~r);
			bus(0, 32'(GDCFG_ADDR_TWO), ~r);
		end
		// every fault mode with the shortest filter and short retry
		for (int m = 0; m < 4; m++)
		begin
			bus(1, 32'(GDCFG_ADDR_ONE), GDCFG_RESET_ONE | 32'(m << 8));
			overcurrent_raw <= 1'b1;
			repeat (70) @(posedge hclk);
			st({m == 3, m != 3, m < 2});
			overcurrent_raw <= 1'b0;
			repeat (70) @(posedge hclk);
			st({m == 3 || m == 1, m == 0 || m == 2, m == 0});
			bus(1, 32'(GDCFG_ADDR_ONE), GDCFG_RESET_ONE | 32'(m << 8) | 32'h00800000);
			repeat (3) @(posedge hclk);
			st(3'b100);
		end
		// long retry wait: fault still held after the short wait would end
		bus(1, 32'(GDCFG_ADDR_ONE), GDCFG_RESET_ONE | 32'h00000900);
		overcurrent_raw <= 1'b1;
		repeat (70) @(posedge hclk);
		overcurrent_raw <= 1'b0;
		repeat (30) @(posedge hclk);
		st(3'b011);
		repeat (30) @(posedge hclk);
		st(3'b100);
		// a 300-cycle spike is shorter than the longest filter
		bus(1, 32'(GDCFG_ADDR_ONE), GDCFG_RESET_ONE | 32'h00003000);
		overcurrent_raw <= 1'b1;
		repeat (300) @(posedge hclk);
		overcurrent_raw <= 1'b0;
		repeat (10) @(posedge hclk);
		st(3'b100);
		// warning reaches the fault pin only while reporting is on
		overtemp_warning_raw <= 1'b1;
		bus(1, 32'(GDCFG_ADDR_ONE), GDCFG_RESET_ONE | 32'h00010000);
		repeat (6) @(posedge hclk);
		st(3'b000);
		bus(1, 32'(GDCFG_ADDR_ONE), GDCFG_RESET_ONE);
		repeat (6) @(posedge hclk);
		st(3'b100);
		finish_test;
	end
endmodule
